// File: rtl/rcw_pkg.sv
// Constants, field layouts and types of the reset controller and watchdog
package rcw_pkg;
    // System clock
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Start-up stretch times selected by the start-up fuse
    localparam int unsigned TOUT_SHORT_NS = 4_100_000;
    localparam int unsigned TOUT_LONG_NS = 65_000_000;
    localparam int unsigned TOUT_SHORT_CYC =
        (TOUT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TOUT_LONG_CYC =
        (TOUT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W = 24;
    localparam logic [DLY_W-1:0] DLY_MIN_CYC = 24'h00000e;
    localparam logic [DLY_W-1:0] XTAL_EXTRA_CYC = 24'h000400;
    localparam logic [1:0] STUP_MIN = 2'h0;
    localparam logic [1:0] STUP_SHORT = 2'h1;
    localparam logic [1:0] STUP_LONG = 2'h2;
    localparam int XTAL_SEL_BIT = 3;
    // Brown-out level fuse code meaning detector off
    localparam logic [2:0] BOD_OFF_CODE = 3'h7;
    // Watchdog change-enable window
    localparam logic [2:0] CEN_WINDOW_CYC = 3'h4;
    // Watchdog period: base oscillator cycles doubled per prescale step
    localparam int WD_CNT_W = 21;
    localparam logic [WD_CNT_W-1:0] WD_BASE_CYC = 21'h000800;
    localparam logic [3:0] WD_PSEL_MAX = 4'h9;
    // APB register map
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_RSTFLAGS = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_WDCTRL = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_REFCTRL = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00c;

    typedef struct packed {
        logic irq_flag;
        logic irq_en;
        logic psel_hi;
        logic change_en;
        logic reset_en;
        logic [2:0] psel_lo;
    } rcw_wdctrl_t;

    typedef struct packed {
        logic wdog;
        logic brownout;
        logic ext;
        logic por;
    } rcw_rstflags_t;

    typedef struct packed {
        logic adc_en;
        logic cmp_ref_sel;
    } rcw_refctrl_t;

    typedef enum logic [1:0] {
        RCW_WD_STOP,
        RCW_WD_IRQ,
        RCW_WD_RESET,
        RCW_WD_BOTH
    } rcw_wdmode_t;

    localparam rcw_wdctrl_t WDCTRL_INIT = 8'h00;
    localparam rcw_rstflags_t RSTFLAGS_INIT = 4'h1;
    localparam rcw_refctrl_t REFCTRL_INIT = 2'h0;
endpackage

// File: rtl/rcw_top.sv
// Reset controller with stretch counter and watchdog with a change-enable window, APB slave
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps

module rcw_top #(
    parameter logic [rcw_pkg::DLY_W-1:0] DLY_SHORT_CYC =
        rcw_pkg::DLY_W'(rcw_pkg::TOUT_SHORT_CYC),
    parameter logic [rcw_pkg::DLY_W-1:0] DLY_LONG_CYC =
        rcw_pkg::DLY_W'(rcw_pkg::TOUT_LONG_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rcw_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    input wire logic ext_reset_n,
    input wire logic brownout_low,
    input wire logic wdog_osc_clk,
    input wire logic [2:0] brownout_level_fuse,
    input wire logic [1:0] startup_time_fuse,
    input wire logic [3:0] clock_select_fuse,
    input wire logic ext_reset_disable_fuse,
    input wire logic wdog_always_on_fuse,
    input wire logic wdog_restart,
    input wire logic wdog_irq_ack,
    output logic sys_reset_n_q,
    output logic port_reset_n_q,
    output logic wdog_irq_q,
    output logic ref_en_q
);
    logic bod_en;
    logic async_src_n;
    logic rst_s1_q;
    logic rst_s2_q;
    logic wdog_pulse_q;
    logic [rcw_pkg::DLY_W-1:0] dly_cnt_q;
    logic [rcw_pkg::DLY_W-1:0] dly_target;
    logic ext_s1_q, ext_s2_q, bod_s1_q, bod_s2_q;
    logic osc_s1_q, osc_s2_q, osc_s3_q;
    logic osc_tick;
    rcw_pkg::rcw_rstflags_t flags_q;
    rcw_pkg::rcw_wdctrl_t ctrl_q;
    rcw_pkg::rcw_wdctrl_t wr_ctrl;
    rcw_pkg::rcw_refctrl_t refctrl_q;
    rcw_pkg::rcw_wdmode_t wd_mode;
    logic [2:0] cen_cnt_q;
    logic [rcw_pkg::WD_CNT_W-1:0] wd_cnt_q;
    logic [rcw_pkg::WD_CNT_W-1:0] wd_limit;
    logic reset_en_eff, irq_en_eff;
    logic wd_expire, irq_set, rst_fire;
    logic setup_ph, wr_commit, hit;
    logic wr_flags, wr_ctrl_en, wr_ref;
    logic unlock, cfg_write;
    logic ref_need;
    logic [31:0] rd_mux;

    // Detector is off only for one fuse code
    assign bod_en = brownout_level_fuse != rcw_pkg::BOD_OFF_CODE;

    // Level sources; the pin's minimum width is filtered in the pad
    assign async_src_n = presetn
        & (ext_reset_n | ext_reset_disable_fuse)
        & ~(bod_en & brownout_low);

    // Release synchroniser, asserted without a clock
    always_ff @(posedge pclk or negedge async_src_n) begin
        if (!async_src_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // Stretch length from start-up fuse, crystal sources add start time
    always_comb begin
        unique case (startup_time_fuse)
            rcw_pkg::STUP_MIN: dly_target = rcw_pkg::DLY_MIN_CYC;
            rcw_pkg::STUP_LONG: dly_target = DLY_LONG_CYC;
            default: dly_target = DLY_SHORT_CYC;
        endcase
        if (clock_select_fuse[rcw_pkg::XTAL_SEL_BIT]) begin
            dly_target = dly_target + rcw_pkg::XTAL_EXTRA_CYC;
        end
    end

    // Delay counter; the watchdog pulse restarts it, count runs after it
    always_ff @(posedge pclk or negedge async_src_n) begin
        if (!async_src_n) begin
            dly_cnt_q <= '0;
            sys_reset_n_q <= 1'b0;
        end else if (!rst_s2_q || wdog_pulse_q) begin
            dly_cnt_q <= '0;
            sys_reset_n_q <= 1'b0;
        end else if (dly_cnt_q == dly_target) begin
            sys_reset_n_q <= 1'b1;
        end else begin
            dly_cnt_q <= dly_cnt_q + 1'b1;
        end
    end

    // Pins drop with any level source before any clock edge
    always_ff @(posedge pclk or negedge async_src_n) begin
        if (!async_src_n) begin
            port_reset_n_q <= 1'b0;
        end else begin
            port_reset_n_q <= sys_reset_n_q;
        end
    end

    // Cause capture: pin and detector are synchronised first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
            bod_s1_q <= 1'b0;
            bod_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_reset_n;
            ext_s2_q <= ext_s1_q;
            bod_s1_q <= brownout_low;
            bod_s2_q <= bod_s1_q;
        end
    end

    // Watchdog oscillator edge, sampled into the pclk domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= wdog_osc_clk;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end
    assign osc_tick = osc_s2_q & ~osc_s3_q;

    // APB decode; one wait-free access cycle after setup
    assign setup_ph = psel & ~penable;
    assign hit = paddr == rcw_pkg::ADDR_RSTFLAGS
        || paddr == rcw_pkg::ADDR_WDCTRL
        || paddr == rcw_pkg::ADDR_REFCTRL
        || paddr == rcw_pkg::ADDR_STATUS;
    assign wr_commit = psel & penable & pready_q & pwrite & hit;
    assign wr_flags = wr_commit && paddr == rcw_pkg::ADDR_RSTFLAGS;
    assign wr_ctrl_en = wr_commit && paddr == rcw_pkg::ADDR_WDCTRL;
    assign wr_ref = wr_commit && paddr == rcw_pkg::ADDR_REFCTRL;
    assign wr_ctrl = pwdata[7:0];

    // Cause flags survive internal reset; only power-on or a write of zero clears them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= rcw_pkg::RSTFLAGS_INIT;
        end else begin
            if (wr_flags) begin
                flags_q <= flags_q & rcw_pkg::rcw_rstflags_t'(pwdata[3:0]);
            end
            // Hardware set wins over a clearing write
            if (!ext_s2_q && !ext_reset_disable_fuse) begin
                flags_q.ext <= 1'b1;
            end
            if (bod_s2_q && bod_en) begin
                flags_q.brownout <= 1'b1;
            end
            if (wdog_pulse_q) begin
                flags_q.wdog <= 1'b1;
            end
        end
    end

    // Effective enables: fuse and reset flag override stored bits
    assign reset_en_eff = wdog_always_on_fuse
        | flags_q.wdog
        | ctrl_q.reset_en;
    assign irq_en_eff = ctrl_q.irq_en & ~wdog_always_on_fuse;
    assign wd_mode = rcw_pkg::rcw_wdmode_t'({reset_en_eff, irq_en_eff});

    // Sequence: unlock only when closed, so the window cannot be extended
    assign unlock = wr_ctrl_en && wr_ctrl.change_en
        && wr_ctrl.reset_en && !ctrl_q.change_en;
    assign cfg_write = wr_ctrl_en && ctrl_q.change_en
        && !wr_ctrl.change_en;

    // Change-enable window counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cen_cnt_q <= '0;
        end else if (unlock || !ctrl_q.change_en) begin
            cen_cnt_q <= '0;
        end else begin
            cen_cnt_q <= cen_cnt_q + 1'b1;
        end
    end

    // Watchdog control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= rcw_pkg::WDCTRL_INIT;
        end else if (!sys_reset_n_q) begin
            ctrl_q <= rcw_pkg::WDCTRL_INIT;
        end else begin
            if (wr_ctrl_en) begin
                ctrl_q.irq_en <= wr_ctrl.irq_en;
            end else if (wdog_irq_ack && wd_mode == rcw_pkg::RCW_WD_BOTH) begin
                ctrl_q.irq_en <= 1'b0;
            end
            if (wr_ctrl_en && wr_ctrl.reset_en) begin
                ctrl_q.reset_en <= 1'b1;
            end else if (cfg_write && !flags_q.wdog) begin
                ctrl_q.reset_en <= 1'b0;
            end
            if (cfg_write) begin
                ctrl_q.psel_hi <= wr_ctrl.psel_hi;
                ctrl_q.psel_lo <= wr_ctrl.psel_lo;
            end
            if (unlock) begin
                ctrl_q.change_en <= 1'b1;
            end else if (cfg_write) begin
                ctrl_q.change_en <= 1'b0;
            end else if (cen_cnt_q == rcw_pkg::CEN_WINDOW_CYC - 3'h1) begin
                ctrl_q.change_en <= 1'b0;
            end
            if (irq_set) begin
                ctrl_q.irq_flag <= 1'b1;
            end else if (wdog_irq_ack
                || (wr_ctrl_en && wr_ctrl.irq_flag)) begin
                ctrl_q.irq_flag <= 1'b0;
            end
        end
    end

    // Reserved codes above the longest period act as the longest
    always_comb begin
        if ({ctrl_q.psel_hi, ctrl_q.psel_lo} > rcw_pkg::WD_PSEL_MAX) begin
            wd_limit = rcw_pkg::WD_BASE_CYC << rcw_pkg::WD_PSEL_MAX;
        end else begin
            wd_limit = rcw_pkg::WD_BASE_CYC
                << {ctrl_q.psel_hi, ctrl_q.psel_lo};
        end
    end

    assign wd_expire = osc_tick && wd_mode != rcw_pkg::RCW_WD_STOP
        && wd_cnt_q == wd_limit - 1'b1;

    // Action on expiry by mode
    always_comb begin
        irq_set = 1'b0;
        rst_fire = 1'b0;
        unique case (wd_mode)
            rcw_pkg::RCW_WD_STOP: begin
                irq_set = 1'b0;
            end
            rcw_pkg::RCW_WD_IRQ: begin
                irq_set = wd_expire;
            end
            rcw_pkg::RCW_WD_RESET: begin
                rst_fire = wd_expire;
            end
            rcw_pkg::RCW_WD_BOTH: begin
                // Unserviced interrupt means the next expiry resets
                irq_set = wd_expire && !ctrl_q.irq_flag;
                rst_fire = wd_expire && ctrl_q.irq_flag;
            end
        endcase
    end

    // Watchdog counter on oscillator ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt_q <= '0;
        end else if (!sys_reset_n_q || wdog_restart || wd_expire
            || wd_mode == rcw_pkg::RCW_WD_STOP) begin
            wd_cnt_q <= '0;
        end else if (osc_tick) begin
            wd_cnt_q <= wd_cnt_q + 1'b1;
        end
    end

    // Internal reset then holds the counter, so the pulse cannot repeat
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_pulse_q <= 1'b0;
        end else begin
            wdog_pulse_q <= rst_fire;
        end
    end

    // Interrupt request, usable as a sleep wake-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_irq_q <= 1'b0;
        end else begin
            wdog_irq_q <= ctrl_q.irq_flag && irq_en_eff;
        end
    end

    // Reference control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refctrl_q <= rcw_pkg::REFCTRL_INIT;
        end else if (!sys_reset_n_q) begin
            refctrl_q <= rcw_pkg::REFCTRL_INIT;
        end else if (wr_ref) begin
            refctrl_q <= rcw_pkg::rcw_refctrl_t'(pwdata[1:0]);
        end
    end

    assign ref_need = bod_en || refctrl_q.cmp_ref_sel || refctrl_q.adc_en;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_en_q <= 1'b0;
        end else begin
            ref_en_q <= ref_need;
        end
    end

    // Read data; control shows the effective enables
    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            rcw_pkg::ADDR_RSTFLAGS: rd_mux[3:0] = flags_q;
            rcw_pkg::ADDR_WDCTRL: begin
                rd_mux[7:0] = ctrl_q;
                rd_mux[6] = irq_en_eff;
                rd_mux[3] = reset_en_eff;
            end
            rcw_pkg::ADDR_REFCTRL: rd_mux[1:0] = refctrl_q;
            rcw_pkg::ADDR_STATUS: rd_mux[3:0] = {ref_en_q, wd_mode,
                sys_reset_n_q};
            default: rd_mux = '0;
        endcase
    end

    // APB answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= setup_ph;
            pslverr_q <= setup_ph && !hit;
            if (setup_ph) begin
                prdata_q <= rd_mux;
            end
        end
    end

    property p_pulse_one;
        @(posedge pclk) disable iff (!presetn)
        wdog_pulse_q |=> !wdog_pulse_q && !sys_reset_n_q;
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("watchdog reset pulse not one cycle");

    property p_delay_start;
        @(posedge pclk) disable iff (!presetn)
        $fell(wdog_pulse_q) |-> dly_cnt_q == '0 ##1 dly_cnt_q == 24'h1;
    endproperty
    a_delay_start: assert property (p_delay_start)
        else $error("delay not started at pulse end");

    property p_stretch;
        @(posedge pclk) disable iff (!presetn)
        $rose(sys_reset_n_q) |-> $past(dly_cnt_q) == $past(dly_target);
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("internal reset released early");

    property p_pins;
        @(posedge pclk) disable iff (!presetn)
        !rst_s2_q |=> !port_reset_n_q;
    endproperty
    a_pins: assert property (p_pins)
        else $error("pins not held in reset");

    property p_fuse;
        @(posedge pclk) disable iff (!presetn)
        wdog_always_on_fuse |-> wd_mode == rcw_pkg::RCW_WD_RESET;
    endproperty
    a_fuse: assert property (p_fuse)
        else $error("always-on fuse not forcing reset mode");

    property p_flag_forces;
        @(posedge pclk) disable iff (!presetn)
        flags_q.wdog |-> reset_en_eff;
    endproperty
    a_flag_forces: assert property (p_flag_forces)
        else $error("reset flag not forcing reset enable");

    property p_window;
        @(posedge pclk) disable iff (!presetn)
        $rose(ctrl_q.change_en) |-> ##[1:4] !ctrl_q.change_en;
    endproperty
    a_window: assert property (p_window)
        else $error("change enable not closed in four cycles");

    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        wdog_restart |=> wd_cnt_q == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not clear counter");

    property p_reset_mode;
        @(posedge pclk) disable iff (!presetn)
        wd_expire && wd_mode == rcw_pkg::RCW_WD_RESET |=> wdog_pulse_q;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("reset mode expiry without reset");

    property p_both_first;
        @(posedge pclk) disable iff (!presetn)
        wd_expire && wd_mode == rcw_pkg::RCW_WD_BOTH && !ctrl_q.irq_flag
            |=> ctrl_q.irq_flag && !wdog_pulse_q ##1 wdog_irq_q;
    endproperty
    a_both_first: assert property (p_both_first)
        else $error("combined mode first expiry wrong");

    property p_ref;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> ref_en_q == $past(ref_need);
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference enable wrong");
endmodule

// File: tb/rcw_core_model.sv
// Core side model: restart instruction and watchdog vector execution
`timescale 1ns/10ps
module rcw_core_model (
    input wire logic pclk,
    input wire logic wdog_irq_q,
    input wire logic ack_on,
    input wire logic kick_on,
    output logic wdog_restart,
    output logic wdog_irq_ack
);
    logic [9:0] tick_q = 10'h000;
    // Outputs settle at the first edge, long before reset is released
    always @(posedge pclk) begin
        tick_q <= tick_q + 10'h001;
        // Kick well inside the shortest period
        wdog_restart <= kick_on && tick_q == 10'h000;
        wdog_irq_ack <= ack_on && wdog_irq_q && !wdog_irq_ack;
    end
endmodule

// File: tb/testbench.sv
// Self-checking bench of the reset controller and watchdog
`timescale 1ns/10ps
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata_q, rd;
    logic pready_q, pslverr_q, err, ext_reset_n = 1, brownout_low = 0;
    logic wdog_osc_clk = 0, ext_reset_disable_fuse = 0;
    logic wdog_always_on_fuse = 0, ack_on = 0, kick_on = 0;
    logic [2:0] brownout_level_fuse = 3'h7;
    logic [1:0] startup_time_fuse = 2'h1;
    logic [3:0] clock_select_fuse = 4'h0;
    logic wdog_restart, wdog_irq_ack, sys_reset_n_q, port_reset_n_q;
    logic wdog_irq_q, ref_en_q;
    int fails = 0, total_checks = 0, n;

    // Short stretch keeps the run brief
    rcw_top #(.DLY_SHORT_CYC(24'h000014), .DLY_LONG_CYC(24'h000028))
    rcw_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata_q, .pready_q, .pslverr_q, .ext_reset_n,
        .brownout_low, .wdog_osc_clk, .brownout_level_fuse,
        .startup_time_fuse, .clock_select_fuse, .ext_reset_disable_fuse,
        .wdog_always_on_fuse, .wdog_restart, .wdog_irq_ack,
        .sys_reset_n_q, .port_reset_n_q, .wdog_irq_q, .ref_en_q);
    rcw_core_model rcw_core_model_i (.pclk, .wdog_irq_q, .ack_on,
        .kick_on, .wdog_restart, .wdog_irq_ack);

    initial begin
        forever #5 pclk = ~pclk;
    end
    // Fast stand-in for the slow oscillator, 8 system cycles
    initial begin
        forever #40 wdog_osc_clk = ~wdog_osc_clk;
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    // Called just after a rising edge; leaves the bus held
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready_q === 1'b1) break;
        end
        rd = prdata_q;
        err = pslverr_q;
        if (k == 20) fails++;
    endtask
    task idle;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task rel_wait;
        for (int k = 0; k < 60 && sys_reset_n_q !== 1'b1; k++)
            @(posedge pclk);
        chk("sys_rst_n", 1, sys_reset_n_q);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task t_por;
        repeat (15) @(posedge pclk);
        chk("sys_early", 0, sys_reset_n_q);
        rel_wait;
        rdchk("flags", 12'h000, 32'h1);
        rdchk("wdctrl", 12'h004, 32'h0);
        apb(0, 12'h010, 32'h0);
        chk("slverr", 1, err);
        idle;
        $display("test por done");
    endtask
    task t_ext;
        ext_reset_n <= 0;
        #1 chk("port_rst", 0, port_reset_n_q);
        @(posedge pclk);
        ext_reset_n <= 1;
        rel_wait;
        rdchk("flags_ext", 12'h000, 32'h3);
        apb(1, 12'h000, 32'h0);
        idle;
        ext_reset_disable_fuse <= 1;
        ext_reset_n <= 0;
        repeat (6) @(posedge pclk);
        chk("pin_off", 1, sys_reset_n_q);
        ext_reset_n <= 1;
        // Let the synchronised pin go high before enabling it again
        repeat (3) @(posedge pclk);
        ext_reset_disable_fuse <= 0;
        @(posedge pclk);
        $display("test ext done");
    endtask
    task t_bod;
        brownout_low <= 1;
        repeat (6) @(posedge pclk);
        chk("bod_off", 1, sys_reset_n_q);
        chk("ref_off", 0, ref_en_q);
        brownout_low <= 0;
        brownout_level_fuse <= 3'h0;
        repeat (3) @(posedge pclk);
        chk("ref_bod", 1, ref_en_q);
        brownout_low <= 1;
        #1 chk("bod_port", 0, port_reset_n_q);
        @(posedge pclk);
        brownout_low <= 0;
        rel_wait;
        rdchk("flags_bod", 12'h000, 32'h4);
        apb(1, 12'h000, 32'h0);
        brownout_level_fuse <= 3'h7;
        apb(1, 12'h008, 32'h1);
        idle;
        repeat (2) @(posedge pclk);
        chk("ref_cmp", 1, ref_en_q);
        apb(1, 12'h008, 32'h0);
        idle;
        $display("test brownout done");
    endtask
    task t_lock;
        apb(1, 12'h004, 32'h08);
        apb(1, 12'h004, 32'h00);
        rdchk("no_unlock", 12'h004, 32'h08);
        apb(1, 12'h004, 32'h18);
        apb(1, 12'h004, 32'h02);
        rdchk("unlocked", 12'h004, 32'h02);
        apb(1, 12'h004, 32'h08);
        apb(1, 12'h004, 32'h18);
        idle;
        repeat (4) @(posedge pclk);
        apb(1, 12'h004, 32'h00);
        rdchk("late", 12'h004, 32'h0a);
        apb(1, 12'h004, 32'h18);
        apb(1, 12'h004, 32'h00);
        idle;
        wdog_always_on_fuse <= 1;
        idle;
        rdchk("forced", 12'h00c, 32'h5);
        wdog_always_on_fuse <= 0;
        idle;
        $display("test lock done");
    endtask
    task t_wirq;
        apb(1, 12'h004, 32'h40);
        idle;
        for (n = 0; n < 17000 && wdog_irq_q !== 1'b1; n++)
            @(posedge pclk);
        chk("irq_on", 1, wdog_irq_q);
        chk("irq_time", 1, n > 16300);
        ack_on <= 1;
        repeat (4) @(posedge pclk);
        chk("irq_ack", 0, wdog_irq_q);
        kick_on <= 1;
        repeat (20000) @(posedge pclk);
        chk("kicked", 0, wdog_irq_q);
        kick_on <= 0;
        ack_on <= 0;
        apb(1, 12'h004, 32'h0);
        idle;
        $display("test irq done");
    endtask
    task t_both;
        apb(1, 12'h004, 32'h48);
        idle;
        for (n = 0; n < 17000 && wdog_irq_q !== 1'b1; n++)
            @(posedge pclk);
        chk("both_irq", 1, wdog_irq_q);
        chk("both_run", 1, sys_reset_n_q);
        for (n = 0; n < 17000 && sys_reset_n_q !== 1'b0; n++)
            @(posedge pclk);
        chk("both_rst", 0, sys_reset_n_q);
        rel_wait;
        $display("test combined done");
    endtask
    task t_wrst;
        apb(1, 12'h004, 32'h08);
        idle;
        for (n = 0; n < 17000 && sys_reset_n_q !== 1'b0; n++)
            @(posedge pclk);
        chk("wd_rst", 0, sys_reset_n_q);
        rel_wait;
        rdchk("flags_wd", 12'h000, 32'h8);
        rdchk("wd_forced", 12'h004, 32'h08);
        idle;
        $display("test wdog reset done");
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        t_por;
        t_ext;
        t_bod;
        t_lock;
        t_wirq;
        t_both;
        t_wrst;
        close_out;
    end
    // Tests need about 85000 cycles
    initial begin
        #1_000_000;
        fails++;
        close_out;
    end
endmodule
